// ===== hw/isp_pkg.sv
// shared constants for the two-wire slave port and its bus master
// assumes a 125 MHz core clock on both ends
package isp_pkg;

	// ***************************************************************
	// register map (word index on the plain register port)
	// ***************************************************************
	localparam int ISP_AW = 3;
	localparam logic [2:0] ISP_REG_BUF = 3'h0;
	localparam logic [2:0] ISP_REG_CTL = 3'h1;
	localparam logic [2:0] ISP_REG_STAT = 3'h2;
	localparam logic [2:0] ISP_REG_ADDR = 3'h3;
	localparam logic [2:0] ISP_REG_IRQ = 3'h4;
	localparam logic [7:0] ISP_RST_VAL = 8'h00;

	// ***************************************************************
	// field positions
	// ***************************************************************
	localparam int ISP_CTL_WRITE_COLLISION = 7;
	localparam int ISP_CTL_OV = 6;
	localparam int ISP_CTL_EN = 5;
	localparam int ISP_CTL_CKP = 4;
	localparam int ISP_STAT_DA = 5;
	localparam int ISP_STAT_P = 4;
	localparam int ISP_STAT_S = 3;
	localparam int ISP_STAT_RW = 2;
	localparam int ISP_STAT_UA = 1;
	localparam int ISP_STAT_BF = 0;
	localparam int ISP_IRQ_FLAG = 0;
	localparam int ISP_IRQ_EN = 1;

	// ***************************************************************
	// modes and address constants
	// ***************************************************************
	localparam logic [3:0] ISP_MODE_MST = 4'h8;
	localparam logic [3:0] ISP_MODE_S7 = 4'h6;
	localparam logic [3:0] ISP_MODE_S10 = 4'h7;
	localparam logic [3:0] ISP_MODE_S7I = 4'he;
	localparam logic [3:0] ISP_MODE_S10I = 4'hf;
	localparam logic [3:0] ISP_MODE_FWM = 4'hb;
	localparam logic [4:0] ISP_HI_PREFIX = 5'h1e;
	localparam logic [3:0] ISP_BITS = 4'h8;
	localparam logic [3:0] ISP_ACK_BIT = 4'h9;

	// ***************************************************************
	// timing
	// ***************************************************************
	localparam logic [7:0] ISP_HALF_CYC = 8'h10;

	typedef enum logic [1:0] {
		ISP_D_IDLE = 2'b00,
		ISP_D_RX = 2'b01,
		ISP_D_TX = 2'b11,
		ISP_D_SKIP = 2'b10
	} isp_dst_t;

	typedef enum logic [1:0] {
		ISP_CMD_START = 2'h0,
		ISP_CMD_WRITE = 2'h1,
		ISP_CMD_READ = 2'h2,
		ISP_CMD_STOP = 2'h3
	} isp_cmd_t;

	typedef enum logic [3:0] {
		ISP_M_IDLE = 4'b0000,
		ISP_M_RS1 = 4'b0001,
		ISP_M_RS2 = 4'b0011,
		ISP_M_RS3 = 4'b0010,
		ISP_M_BLO = 4'b0110,
		ISP_M_BHI = 4'b0111,
		ISP_M_P1 = 4'b0101,
		ISP_M_P2 = 4'b0100,
		ISP_M_P3 = 4'b1100
	} isp_mst_t;

endpackage : isp_pkg

// ===== hw/isp_link_if.sv
// open-drain two-wire link between the slave port and a bus master
// each party only pulls low; the wire level is worked out here
`timescale 1ns/1ps
interface isp_link_if;
	logic scl_dev_oe;
	logic sda_dev_oe;
	logic scl_mst_oe;
	logic sda_mst_oe;
	logic scl;
	logic sda;

	assign scl = ~(scl_dev_oe | scl_mst_oe);
	assign sda = ~(sda_dev_oe | sda_mst_oe);

	modport dev (output scl_dev_oe, output sda_dev_oe, input scl, input sda);
	modport mst (output scl_mst_oe, output sda_mst_oe, input scl, input sda);
endinterface : isp_link_if

// ===== hw/isp_slave_dev.sv
// two-wire slave port with buffer, control, status and address registers
// assumes software on the plain register port and a master on the link
`timescale 1ns/1ps
// How it works
// - nothing runs until port enable set
// - mode select picks master, slave widths, interrupts
// - pins driven only open-drain in slave mode
// - transmitter overrides data pin when driving
// - match or data byte: acknowledge, buffer load
// - full or overflow: no acknowledge, flag anyway
// - buffer read clears full; overflow cleared by software
// - wait start, shift eight bits on rise
// - compare bits 7:1 at eighth fall
// - match: buffer, full, acknowledge, flag at ninth
// - 10-bit high byte is 11110 A9 A8 0
// - high byte sets update, holds clock until address write
// - low byte sets update again, address write releases
// - repeated-start read high byte: flag and full, no update
// - write direction clears direction, address buffered
// - flag set every byte once addressed, software clears it
// - read direction: set direction, ack, hold clock
// - buffer write loads shifter, release bit frees clock
// - transmit bits shift out on falling edges
// - master checks clock level before next pulse
// - latch master ack on ninth rise, flag ninth fall
// - nack ends transfer; ack waits next load
module isp_slave_dev (
	input wire logic core_clk_in,
	input wire logic rst_b_in,
	isp_link_if.dev link,
	input wire logic [isp_pkg::ISP_AW-1:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [7:0] reg_rdata_out,
	output logic irq_flag_out
);
	import isp_pkg::*;

	// ***************************************************************
	// state
	// ***************************************************************
	isp_dst_t st_ff;
	logic [7:0] buf_ff, addr_ff, sr_ff, rdata_ff;
	logic [3:0] mode_ff, cnt_ff;
	logic write_collision_ff, ov_ff, en_ff, ckp_ff;
	logic da_ff, p_ff, s_ff, rw_ff, ua_ff, bf_ff;
	logic irq_ff, ie_ff;
	logic addr_ph_ff, lo_ph_ff, ten_ok_ff, tx_pend_ff;
	logic ack_oe_ff, tx_drv_ff, stretch_ff, sda_oe_ff, mack_ff;
	logic scl_s1_ff, scl_s2_ff, scl_s3_ff, sda_s1_ff, sda_s2_ff, sda_s3_ff;

	// ***************************************************************
	// link sampling and decode
	// ***************************************************************
	always_ff @(posedge core_clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			{scl_s1_ff, scl_s2_ff, scl_s3_ff} <= 3'h7;
			{sda_s1_ff, sda_s2_ff, sda_s3_ff} <= 3'h7;
		end
		else
		begin
			{scl_s1_ff, scl_s2_ff, scl_s3_ff} <= {link.scl, scl_s1_ff, scl_s2_ff};
			{sda_s1_ff, sda_s2_ff, sda_s3_ff} <= {link.sda, sda_s1_ff, sda_s2_ff};
		end
	end

	wire scl_rise = scl_s2_ff & ~scl_s3_ff;
	wire scl_fall = ~scl_s2_ff & scl_s3_ff;
	wire start_det = scl_s2_ff & scl_s3_ff & sda_s3_ff & ~sda_s2_ff;
	wire stop_det = scl_s2_ff & scl_s3_ff & ~sda_s3_ff & sda_s2_ff;
	// master codes leave the slave idle
	wire slave_mode = (mode_ff == ISP_MODE_S7) | (mode_ff == ISP_MODE_S10) |
		(mode_ff == ISP_MODE_S7I) | (mode_ff == ISP_MODE_S10I);
	wire slave_on = en_ff & slave_mode;
	wire ten = mode_ff[0];
	wire ss_int = mode_ff[3];
	wire ovf = bf_ff | ov_ff;
	wire match7 = sr_ff[7:1] == addr_ff[7:1];
	wire is_hi10 = (sr_ff[7:3] == ISP_HI_PREFIX) & match7;
	wire addr_hit = lo_ph_ff ? (sr_ff == addr_ff) :
		ten ? (is_hi10 & (~sr_ff[0] | ten_ok_ff)) : match7;
	wire byte_hit = ~addr_ph_ff | addr_hit;
	wire set_ua = addr_ph_ff & ten & (lo_ph_ff | ~sr_ff[0]);
	wire go_tx = addr_ph_ff & ~lo_ph_ff & sr_ff[0];
	wire rx_ev8 = (st_ff == ISP_D_RX) & scl_fall & (cnt_ff == ISP_BITS);
	wire rx_ev9 = (st_ff == ISP_D_RX) & scl_fall & (cnt_ff == ISP_ACK_BIT);
	wire tx_busy = (st_ff == ISP_D_TX) & ~stretch_ff;

	// ***************************************************************
	// register read path
	// ***************************************************************
	wire [7:0] ctl_rd = {write_collision_ff, ov_ff, en_ff, ckp_ff, mode_ff};
	wire [7:0] stat_rd = {2'b00, da_ff, p_ff, s_ff, rw_ff, ua_ff, bf_ff};
	wire [7:0] irq_rd = {6'h00, ie_ff, irq_ff};
	wire [7:0] rd_mux = (reg_addr_in == ISP_REG_BUF) ? buf_ff :
		(reg_addr_in == ISP_REG_CTL) ? ctl_rd :
		(reg_addr_in == ISP_REG_STAT) ? stat_rd :
		(reg_addr_in == ISP_REG_ADDR) ? addr_ff :
		(reg_addr_in == ISP_REG_IRQ) ? irq_rd : 8'h00;
	wire wr_buf = reg_wr_in & (reg_addr_in == ISP_REG_BUF);
	wire wr_ctl = reg_wr_in & (reg_addr_in == ISP_REG_CTL);
	wire wr_addr = reg_wr_in & (reg_addr_in == ISP_REG_ADDR);
	wire wr_irq = reg_wr_in & (reg_addr_in == ISP_REG_IRQ);
	wire rd_buf = reg_rd_in & (reg_addr_in == ISP_REG_BUF);

	// ***************************************************************
	// registers and link engine; hardware sets follow software clears
	// ***************************************************************
	always_ff @(posedge core_clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			st_ff <= ISP_D_IDLE;
			{buf_ff, addr_ff, sr_ff, rdata_ff} <= {4{ISP_RST_VAL}};
			{write_collision_ff, ov_ff, en_ff, ckp_ff, mode_ff} <= ISP_RST_VAL;
			{da_ff, p_ff, s_ff, rw_ff, ua_ff, bf_ff} <= 6'h00;
			{irq_ff, ie_ff, addr_ph_ff, lo_ph_ff, ten_ok_ff, tx_pend_ff} <= 6'h00;
			{ack_oe_ff, tx_drv_ff, stretch_ff, sda_oe_ff, mack_ff} <= 5'h00;
			cnt_ff <= 4'h0;
		end
		else
		begin
			rdata_ff <= reg_rd_in ? rd_mux : 8'h00;
			if (rd_buf)
				bf_ff <= 1'b0;
			if (wr_ctl)
			begin
				{write_collision_ff, ov_ff, en_ff, ckp_ff, mode_ff} <= reg_wdata_in;
				if (reg_wdata_in[ISP_CTL_CKP] && st_ff == ISP_D_TX)
					stretch_ff <= 1'b0;
			end
			if (wr_irq)
				{ie_ff, irq_ff} <= reg_wdata_in[ISP_IRQ_EN:ISP_IRQ_FLAG];
			if (wr_addr)
			begin
				addr_ff <= reg_wdata_in;
				if (ua_ff)
				begin
					ua_ff <= 1'b0;
					stretch_ff <= 1'b0;
				end
			end
			if (wr_buf)
			begin
				if (tx_busy)
					write_collision_ff <= 1'b1;
				else
				begin
					buf_ff <= reg_wdata_in;
					if (st_ff == ISP_D_TX)
					begin
						sr_ff <= reg_wdata_in;
						tx_drv_ff <= 1'b1;
					end
				end
			end
			sda_oe_ff <= slave_on & (ack_oe_ff | (tx_drv_ff & ~sr_ff[7]));
			if (!slave_on)
			begin
				st_ff <= ISP_D_IDLE;
				{ack_oe_ff, tx_drv_ff, stretch_ff} <= 3'h0;
				{addr_ph_ff, lo_ph_ff, ten_ok_ff, s_ff, p_ff} <= 5'h00;
				cnt_ff <= 4'h0;
			end
			else if (start_det)
			begin
				st_ff <= ISP_D_RX;
				cnt_ff <= 4'h0;
				{addr_ph_ff, lo_ph_ff, ack_oe_ff, tx_drv_ff, stretch_ff} <= 5'h10;
				{s_ff, p_ff} <= 2'b10;
				if (ss_int)
					irq_ff <= 1'b1;
			end
			else if (stop_det)
			begin
				st_ff <= ISP_D_IDLE;
				{ack_oe_ff, tx_drv_ff, stretch_ff, ten_ok_ff} <= 4'h0;
				{s_ff, p_ff} <= 2'b01;
				if (ss_int)
					irq_ff <= 1'b1;
			end
			else
			begin
				unique case (st_ff)
					ISP_D_RX:
					begin
						if (scl_rise && cnt_ff < ISP_BITS)
							sr_ff <= {sr_ff[6:0], sda_s2_ff};
						if (scl_rise && cnt_ff < ISP_ACK_BIT)
							cnt_ff <= cnt_ff + 4'h1;
						if (rx_ev8)
						begin
							if (!byte_hit)
								st_ff <= ISP_D_SKIP;
							else
							begin
								if (!ovf)
								begin
									buf_ff <= sr_ff;
									bf_ff <= 1'b1;
									ack_oe_ff <= 1'b1;
								end
								else
									ov_ff <= 1'b1;
								da_ff <= ~addr_ph_ff;
								if (addr_ph_ff && !lo_ph_ff)
									rw_ff <= sr_ff[0];
								if (set_ua)
									ua_ff <= 1'b1;
								tx_pend_ff <= go_tx;
								lo_ph_ff <= addr_ph_ff & ten & ~lo_ph_ff & ~sr_ff[0];
								if (addr_ph_ff && (lo_ph_ff || !ten || sr_ff[0]))
									addr_ph_ff <= 1'b0;
								if (addr_ph_ff && ten)
									ten_ok_ff <= lo_ph_ff | sr_ff[0];
							end
						end
						if (rx_ev9)
						begin
							ack_oe_ff <= 1'b0;
							irq_ff <= 1'b1;
							cnt_ff <= 4'h0;
							if (ua_ff || tx_pend_ff)
								stretch_ff <= 1'b1;
							if (tx_pend_ff)
							begin
								st_ff <= ISP_D_TX;
								ckp_ff <= 1'b0;
							end
						end
					end
					ISP_D_TX:
					begin
						if (scl_rise)
							cnt_ff <= cnt_ff + 4'h1;
						if (scl_rise && cnt_ff == ISP_BITS)
							mack_ff <= sda_s2_ff;
						if (scl_fall && cnt_ff < ISP_BITS)
							sr_ff <= {sr_ff[6:0], 1'b1};
						if (scl_fall && cnt_ff == ISP_BITS)
							tx_drv_ff <= 1'b0;
						if (scl_fall && cnt_ff == ISP_ACK_BIT)
						begin
							irq_ff <= 1'b1;
							cnt_ff <= 4'h0;
							if (mack_ff)
								st_ff <= ISP_D_SKIP;
							else
							begin
								stretch_ff <= 1'b1;
								ckp_ff <= 1'b0;
							end
						end
					end
					ISP_D_IDLE, ISP_D_SKIP:
						cnt_ff <= 4'h0;
				endcase
			end
		end
	end

	// ***************************************************************
	// outputs
	// ***************************************************************
	assign link.scl_dev_oe = stretch_ff;
	assign link.sda_dev_oe = sda_oe_ff;
	assign reg_rdata_out = rdata_ff;
	assign irq_flag_out = irq_ff & ie_ff;

endmodule : isp_slave_dev

// ===== hw/isp_bus_master.sv
// two-wire bus master end: start, byte write, byte read, stop
// assumes one command at a time from logic on the same clock
`timescale 1ns/1ps
module isp_bus_master #(
	parameter logic [7:0] HALF_CYC = isp_pkg::ISP_HALF_CYC
) (
	input wire logic core_clk_in,
	input wire logic rst_b_in,
	isp_link_if.mst link,
	input wire logic cmd_valid_in,
	input wire isp_pkg::isp_cmd_t cmd_in,
	input wire logic [7:0] wdata_in,
	input wire logic nack_in,
	output logic ready_out,
	output logic [7:0] rdata_out,
	output logic nack_out
);
	import isp_pkg::*;

	isp_mst_t st_ff;
	logic [7:0] tmr_ff;
	logic [8:0] tx_ff, rx_ff;
	logic [3:0] cnt_ff;
	logic scl_oe_ff, sda_oe_ff;
	logic scl_s1_ff, scl_s2_ff, sda_s1_ff, sda_s2_ff;

	wire tick = tmr_ff == 8'h00;
	wire [8:0] first9 = (cmd_in == ISP_CMD_WRITE) ? {wdata_in, 1'b1} : {8'hff, nack_in};

	always_ff @(posedge core_clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
			{scl_s1_ff, scl_s2_ff, sda_s1_ff, sda_s2_ff} <= 4'hf;
		else
			{scl_s1_ff, scl_s2_ff, sda_s1_ff, sda_s2_ff} <= {link.scl, scl_s1_ff, link.sda, sda_s1_ff};
	end

	// ***************************************************************
	// bus sequencer
	// ***************************************************************
	always_ff @(posedge core_clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			st_ff <= ISP_M_IDLE;
			tmr_ff <= 8'h00;
			{tx_ff, rx_ff} <= 18'h00000;
			cnt_ff <= 4'h0;
			{scl_oe_ff, sda_oe_ff} <= 2'b00;
		end
		else
		begin
			if (!tick)
				tmr_ff <= tmr_ff - 8'h01;
			unique case (st_ff)
				ISP_M_IDLE:
					if (cmd_valid_in)
					begin
						tmr_ff <= HALF_CYC;
						unique case (cmd_in)
							ISP_CMD_START:
							begin
								sda_oe_ff <= 1'b0;
								st_ff <= ISP_M_RS1;
							end
							ISP_CMD_WRITE, ISP_CMD_READ:
							begin
								tx_ff <= first9;
								sda_oe_ff <= ~first9[8];
								cnt_ff <= 4'h0;
								st_ff <= ISP_M_BLO;
							end
							ISP_CMD_STOP:
							begin
								sda_oe_ff <= 1'b1;
								st_ff <= ISP_M_P1;
							end
						endcase
					end
				ISP_M_RS1:
					if (tick)
					begin
						scl_oe_ff <= 1'b0;
						tmr_ff <= HALF_CYC;
						st_ff <= ISP_M_RS2;
					end
				ISP_M_RS2:
					if (!scl_s2_ff)
						tmr_ff <= HALF_CYC;
					else if (tick)
					begin
						sda_oe_ff <= 1'b1;
						tmr_ff <= HALF_CYC;
						st_ff <= ISP_M_RS3;
					end
				ISP_M_RS3:
					if (tick)
					begin
						scl_oe_ff <= 1'b1;
						st_ff <= ISP_M_IDLE;
					end
				ISP_M_BLO:
					if (tick)
					begin
						scl_oe_ff <= 1'b0;
						tmr_ff <= HALF_CYC;
						st_ff <= ISP_M_BHI;
					end
				ISP_M_BHI:
					if (!scl_s2_ff)
						tmr_ff <= HALF_CYC;
					else if (tick)
					begin
						rx_ff <= {rx_ff[7:0], sda_s2_ff};
						tx_ff <= {tx_ff[7:0], 1'b1};
						scl_oe_ff <= 1'b1;
						cnt_ff <= cnt_ff + 4'h1;
						tmr_ff <= HALF_CYC;
						if (cnt_ff == ISP_BITS)
							st_ff <= ISP_M_IDLE;
						else
						begin
							sda_oe_ff <= ~tx_ff[7];
							st_ff <= ISP_M_BLO;
						end
					end
				ISP_M_P1:
					if (tick)
					begin
						scl_oe_ff <= 1'b0;
						tmr_ff <= HALF_CYC;
						st_ff <= ISP_M_P2;
					end
				ISP_M_P2:
					if (!scl_s2_ff)
						tmr_ff <= HALF_CYC;
					else if (tick)
					begin
						sda_oe_ff <= 1'b0;
						tmr_ff <= HALF_CYC;
						st_ff <= ISP_M_P3;
					end
				ISP_M_P3:
					if (tick)
						st_ff <= ISP_M_IDLE;
				default:
					st_ff <= ISP_M_IDLE;
			endcase
		end
	end

	assign link.scl_mst_oe = scl_oe_ff;
	assign link.sda_mst_oe = sda_oe_ff;
	assign ready_out = st_ff == ISP_M_IDLE;
	assign rdata_out = rx_ff[8:1];
	assign nack_out = rx_ff[0];

endmodule : isp_bus_master

// ===== verification/isp_link_properties.sv
// link checker: open-drain line rules for the slave port and the bus master
// assumes the link signals and the core clock and reset shared by both ends
`timescale 1ns/1ps
module isp_link_properties (
	input wire logic core_clk_in,
	input wire logic rst_b_in,
	input wire logic scl_dev_oe,
	input wire logic sda_dev_oe,
	input wire logic scl_mst_oe,
	input wire logic sda_mst_oe,
	input wire logic scl,
	input wire logic sda
);
	logic scl_ff;
	logic sda_ff;
	logic first_ff;
	logic seen_ff;
	logic [3:0] cnt_ff;
	wire start_det = scl && scl_ff && sda_ff && !sda;
	wire rise_det = scl && !scl_ff;
	wire ninth_rise = rise_det && (cnt_ff == 4'h9);
	wire [3:0] nxt_cnt = start_det ? 4'h0 : (ninth_rise ? 4'h1 : (rise_det ? cnt_ff + 4'h1 : cnt_ff));
	wire nxt_first = start_det | (first_ff & ~ninth_rise);

	// ***************************************************************
	// clock pulses counted per byte since the last start, wrapping to one after the ninth
	// ***************************************************************
	always_ff @(posedge core_clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			scl_ff <= 1'b1;
			sda_ff <= 1'b1;
			first_ff <= 1'b0;
			seen_ff <= 1'b0;
			cnt_ff <= 4'h0;
		end
		else
		begin
			scl_ff <= scl;
			sda_ff <= sda;
			first_ff <= nxt_first;
			seen_ff <= seen_ff | start_det;
			cnt_ff <= nxt_cnt;
		end
	end

	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (!rst_b_in);

	sequence start_seq;
		scl && sda ##1 scl && !sda;
	endsequence

	high_stable_a: assert property (scl && $past(scl) |-> $stable(sda_dev_oe))
		else $error("slave data changed while clock high");
	data_setup_a: assert property ($changed(sda_dev_oe) |-> !scl ##1 !scl)
		else $error("slave data changed without setup");
	stretch_at_ninth_a: assert property ($rose(scl_dev_oe) |-> cnt_ff == 4'h9 && $past(scl_mst_oe))
		else $error("clock stretch began outside the ninth low");
	release_at_ninth_a: assert property ($fell(scl_dev_oe) |-> cnt_ff == 4'h9)
		else $error("clock stretch ended outside the ninth low");
	quiet_before_start_a: assert property (!seen_ff |-> !sda_dev_oe && !scl_dev_oe)
		else $error("slave drove the link before any start");
	addr_listen_a: assert property (first_ff && cnt_ff != 4'h9 && scl && scl_ff |-> !sda_dev_oe)
		else $error("slave drove data during the address bits");
	start_quiet_a: assert property (start_seq |-> (!sda_dev_oe && !scl_dev_oe) [*4])
		else $error("slave drove the link at a start");
	master_high_a: assert property ($rose(scl) |-> !scl_mst_oe [*8])
		else $error("master cut a clock high short");
endmodule : isp_link_properties

// ===== verification/i2c_slave_port_tb.sv
// bench: slave port and bus master face each other across one link
// assumes the package, the link interface and the link checker
`timescale 1ns/1ps
module i2c_slave_port_tb;
	import isp_pkg::*;
	logic core_clk_in = 1'b0;
	logic rst_b_in = 1'b0;
	logic [2:0] reg_addr = 3'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic irq_flag;
	logic cmd_valid = 1'b0;
	isp_cmd_t cmd = ISP_CMD_START;
	logic [7:0] wdata = 8'h00;
	logic nack_in = 1'b0;
	logic ready;
	logic [7:0] rdata;
	logic nack;
	logic [7:0] v;
	int fail_count = 0;
	int n_compared = 0;

	isp_link_if link_if ();
	isp_slave_dev isp_slave_dev_inst (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .link(link_if.dev),
		.reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
		.reg_rdata_out(reg_rdata), .irq_flag_out(irq_flag));
	isp_bus_master isp_bus_master_inst (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .link(link_if.mst),
		.cmd_valid_in(cmd_valid), .cmd_in(cmd), .wdata_in(wdata), .nack_in(nack_in), .ready_out(ready),
		.rdata_out(rdata), .nack_out(nack));
	isp_link_properties isp_link_properties_inst (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in),
		.scl_dev_oe(link_if.scl_dev_oe), .sda_dev_oe(link_if.sda_dev_oe), .scl_mst_oe(link_if.scl_mst_oe),
		.sda_mst_oe(link_if.sda_mst_oe), .scl(link_if.scl), .sda(link_if.sda));

	always #4 core_clk_in = ~core_clk_in;

	// ***************************************************************
	// bus and link tasks
	// ***************************************************************
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			fail_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk_in);
		reg_wr <= 1'b0;
		@(posedge core_clk_in);
	endtask : wr
	task automatic rd(input logic [2:0] a);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk_in);
		reg_rd <= 1'b0;
		@(posedge core_clk_in);
		v = reg_rdata;
	endtask : rd
	task automatic rc(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
		rd(a);
		chk(v & m, e);
	endtask : rc
	task automatic mc(input isp_cmd_t c, input logic [7:0] d, input logic n);
		int i;
		cmd <= c;
		wdata <= d;
		nack_in <= n;
		cmd_valid <= 1'b1;
		@(posedge core_clk_in);
		cmd_valid <= 1'b0;
		@(posedge core_clk_in);
		for (i = 0; i < 4000 && ready !== 1'b1; i++)
			@(posedge core_clk_in);
		chk(ready, 1'b1);
		// slave flags land a few cycles after the last clock fall
		repeat (8) @(posedge core_clk_in);
	endtask : mc
	task automatic ms(input isp_cmd_t c);
		mc(c, 8'h00, 1'b0);
	endtask : ms
	task automatic wb(input logic [7:0] d, input logic e);
		mc(ISP_CMD_WRITE, d, 1'b0);
		chk(nack, e);
	endtask : wb
	task automatic rb(input logic n, input logic [7:0] e);
		mc(ISP_CMD_READ, 8'h00, n);
		chk(rdata, e);
	endtask : rb

	// ***************************************************************
	// scenarios
	// ***************************************************************
	task automatic t_reset;
		rc(ISP_REG_CTL, 8'hff, ISP_RST_VAL);
		rc(ISP_REG_STAT, 8'hff, ISP_RST_VAL);
		rc(3'h6, 8'hff, 8'h00);
		$display("reset test done");
	endtask : t_reset
	task automatic t_modes;
		logic [7:0] ctl [7] = '{8'h06, 8'h26, 8'h27, 8'h28, 8'h2b, 8'h2e, 8'h2f};
		logic nak [7] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
		logic irq_exp [7] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
		wr(ISP_REG_ADDR, 8'ha0);
		foreach (ctl[i])
		begin
			wr(ISP_REG_CTL, ctl[i]);
			wr(ISP_REG_IRQ, 8'h00);
			ms(ISP_CMD_START);
			wb(8'ha0, nak[i]);
			rd(ISP_REG_BUF);
			ms(ISP_CMD_STOP);
			rc(ISP_REG_IRQ, 8'h01, {7'h00, irq_exp[i]});
		end
		$display("mode test done");
	endtask : t_modes
	task automatic t_rx7;
		wr(ISP_REG_CTL, 8'h26);
		wr(ISP_REG_IRQ, 8'h02);
		ms(ISP_CMD_START);
		wb(8'ha2, 1'b1);
		ms(ISP_CMD_START);
		wb(8'ha0, 1'b0);
		chk(irq_flag, 1'b1);
		rc(ISP_REG_STAT, 8'h05, 8'h01);
		rc(ISP_REG_BUF, 8'hff, 8'ha0);
		rc(ISP_REG_STAT, 8'h01, 8'h00);
		wr(ISP_REG_IRQ, 8'h02);
		chk(irq_flag, 1'b0);
		wb(8'h3c, 1'b0);
		wr(ISP_REG_IRQ, 8'h02);
		wb(8'h55, 1'b1);
		chk(irq_flag, 1'b1);
		rc(ISP_REG_BUF, 8'hff, 8'h3c);
		rc(ISP_REG_CTL, 8'h40, 8'h40);
		ms(ISP_CMD_STOP);
		wr(ISP_REG_CTL, 8'h26);
		rc(ISP_REG_CTL, 8'hff, 8'h26);
		$display("receive test done");
	endtask : t_rx7
	task automatic t_tx7;
		ms(ISP_CMD_START);
		wb(8'ha1, 1'b0);
		rc(ISP_REG_STAT, 8'h05, 8'h05);
		rc(ISP_REG_BUF, 8'hff, 8'ha1);
		wr(ISP_REG_IRQ, 8'h02);
		wr(ISP_REG_BUF, 8'h96);
		wr(ISP_REG_CTL, 8'h36);
		rb(1'b0, 8'h96);
		chk(irq_flag, 1'b1);
		chk(link_if.scl_dev_oe, 1'b1);
		wr(ISP_REG_IRQ, 8'h02);
		wr(ISP_REG_BUF, 8'h5a);
		wr(ISP_REG_CTL, 8'h36);
		rb(1'b1, 8'h5a);
		chk(link_if.scl_dev_oe, 1'b0);
		ms(ISP_CMD_STOP);
		$display("transmit test done");
	endtask : t_tx7
	task automatic t_rx10;
		wr(ISP_REG_CTL, 8'h27);
		wr(ISP_REG_ADDR, 8'hf2);
		wr(ISP_REG_IRQ, 8'h02);
		ms(ISP_CMD_START);
		wb(8'hf2, 1'b0);
		chk(link_if.scl_dev_oe, 1'b1);
		rc(ISP_REG_STAT, 8'h03, 8'h03);
		rd(ISP_REG_BUF);
		wr(ISP_REG_IRQ, 8'h02);
		wr(ISP_REG_ADDR, 8'h34);
		rc(ISP_REG_STAT, 8'h02, 8'h00);
		chk(link_if.scl_dev_oe, 1'b0);
		wb(8'h34, 1'b0);
		rc(ISP_REG_STAT, 8'h03, 8'h03);
		rc(ISP_REG_BUF, 8'hff, 8'h34);
		wr(ISP_REG_IRQ, 8'h02);
		wr(ISP_REG_ADDR, 8'hf2);
		chk(link_if.scl_dev_oe, 1'b0);
		ms(ISP_CMD_START);
		wb(8'hf3, 1'b0);
		chk(irq_flag, 1'b1);
		rc(ISP_REG_STAT, 8'h07, 8'h05);
		rd(ISP_REG_BUF);
		wr(ISP_REG_BUF, 8'hc3);
		wr(ISP_REG_CTL, 8'h37);
		rb(1'b1, 8'hc3);
		ms(ISP_CMD_STOP);
		$display("wide address test done");
	endtask : t_rx10

	task automatic wrap_up;
		$display("compared %0d, mismatched %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : wrap_up

	initial
	begin
		#400000;
		fail_count++;
		wrap_up;
	end

	initial
	begin
		repeat (3) @(posedge core_clk_in);
		rst_b_in <= 1'b1;
		@(posedge core_clk_in);
		t_reset;
		t_modes;
		t_rx7;
		t_tx7;
		t_rx10;
		wrap_up;
	end
endmodule : i2c_slave_port_tb
